// >>> src/aol_top.sv
// Conditioning of the first analog output, as analog or as logic output.
// Assumes configuration and assigned information come from logic on CLK.
//
// Function
// - Logic state 0 drives minimum output level, state 1 drives maximum.
// - Logic output changes to active only after output_delay_time, 0 to 60000 ms, default 0.
// - No_drive_fault and brake_control force output_delay_time to zero, unchangeable.
// - Active_high outputs 1 while information true; active_low outputs 0; default high.
// - No_drive_fault, brake_control, line_contactor lock level at active_high, rejecting changes.
// - Output_holding_time 0 to 9999 ms, default 0; forced zero for fault, brake.
// - Analog: lower limit gives minimum output, upper limit gives maximum output.
// - Minimum output above maximum is accepted, giving inverted mapping.
// - Scaling percentages refer to span, upper limit minus lower limit.
// - Effective lower limit is lower limit plus span times scale_min_percent.
// - Effective upper limit is lower limit plus span times scale_max_percent.
`timescale 1ns/10ps
`default_nettype none
module aol_top
    import aol_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = aol_pkg::CYCLES_PER_MS
)(
    input  wire logic                     CLK,
    input  wire logic                     ARST_N,
    input  wire logic                     LOGIC_MODE,
    input  wire aol_pkg::aol_src_e        LOGIC_OUTPUT_ASSIGN,
    input  wire logic                     ASSIGNED_INFO,
    input  wire aol_pkg::aol_level_e      OUTPUT_ACTIVE_LEVEL,
    input  wire logic [aol_pkg::MS_W-1:0] OUTPUT_DELAY_TIME,
    input  wire logic [aol_pkg::MS_W-1:0] OUTPUT_HOLDING_TIME,
    input  wire logic [aol_pkg::VAL_W-1:0] OUT_MIN_VALUE,
    input  wire logic [aol_pkg::VAL_W-1:0] OUT_MAX_VALUE,
    input  wire logic signed [aol_pkg::VAL_W-1:0] PARAM_VALUE,
    input  wire logic signed [aol_pkg::VAL_W-1:0] PARAM_LOWER_LIMIT,
    input  wire logic signed [aol_pkg::VAL_W-1:0] PARAM_UPPER_LIMIT,
    input  wire logic [aol_pkg::PCT_W-1:0] SCALE_MIN_PERCENT,
    input  wire logic [aol_pkg::PCT_W-1:0] SCALE_MAX_PERCENT,
    output logic [aol_pkg::VAL_W-1:0]     ANALOG_OUTPUT_ONE,
    output logic                          LOGIC_STATE,
    output logic                          CHANGE_PENDING,
    output aol_pkg::aol_level_e           EFF_ACTIVE_LEVEL,
    output logic [aol_pkg::MS_W-1:0]      EFF_DELAY_TIME,
    output logic [aol_pkg::MS_W-1:0]      EFF_HOLDING_TIME,
    output logic                          LEVEL_REJECTED
);
    import aol_pkg::*;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        aol_state_e         st;
        logic               state;
        logic               target;
        logic [TICK_W-1:0]  tick;
        logic [MS_W-1:0]    ms_left;
        aol_level_e         level;
        logic [MS_W-1:0]    delay;
        logic [MS_W-1:0]    hold;
        logic               rejected;
        logic [VAL_W-1:0]   out;
    } aol_top_s;

    aol_top_s r;
    aol_top_s next_r;

    logic [VAL_W-1:0] scaled;

    // ------------------------------------------------------------
    // Analog scaling path
    // ------------------------------------------------------------
    aol_scale u_scale (
        .clk       (CLK),
        .arst_n    (ARST_N),
        .param     (PARAM_VALUE),
        .lim_lo    (PARAM_LOWER_LIMIT),
        .lim_hi    (PARAM_UPPER_LIMIT),
        .scale_min (SCALE_MIN_PERCENT),
        .scale_max (SCALE_MAX_PERCENT),
        .out_min   (OUT_MIN_VALUE),
        .out_max   (OUT_MAX_VALUE),
        .out_val   (scaled)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic            zero_times;
        logic            lock_level;
        logic            raw;
        logic [MS_W-1:0] wait_ms;
        zero_times = 1'b0;
        lock_level = 1'b0;
        raw        = 1'b0;
        wait_ms    = '0;
        next_r = r;

        // Effective configuration; out-of-range times saturate
        zero_times = (LOGIC_OUTPUT_ASSIGN == AOL_SRC_NO_DRIVE_FAULT) ||
                     (LOGIC_OUTPUT_ASSIGN == AOL_SRC_BRAKE_CONTROL);
        lock_level = zero_times || (LOGIC_OUTPUT_ASSIGN == AOL_SRC_LINE_CONTACTOR);
        if (zero_times) begin
            next_r.delay = DELAY_RST_MS;
            next_r.hold  = HOLD_RST_MS;
        end else begin
            next_r.delay = (OUTPUT_DELAY_TIME > DELAY_MAX_MS) ? DELAY_MAX_MS
                                                               : OUTPUT_DELAY_TIME;
            next_r.hold  = (OUTPUT_HOLDING_TIME > HOLD_MAX_MS) ? HOLD_MAX_MS
                                                                : OUTPUT_HOLDING_TIME;
        end
        if (lock_level) begin
            next_r.level    = AOL_LVL_ACTIVE_HIGH;
            next_r.rejected = (OUTPUT_ACTIVE_LEVEL == AOL_LVL_ACTIVE_LOW);
        end else begin
            next_r.level    = OUTPUT_ACTIVE_LEVEL;
            next_r.rejected = 1'b0;
        end

        // Polarity, from the registered level, so a lock acts one clock later
        raw = ASSIGNED_INFO ^ (r.level == AOL_LVL_ACTIVE_LOW);
        // Delay governs the way into active, holding time the way out
        wait_ms = ASSIGNED_INFO ? r.delay : r.hold;

        case (r.st)
            AOL_ST_STABLE: begin
                if (raw != r.state) begin
                    if (wait_ms == '0) begin
                        next_r.state = raw;
                    end else begin
                        next_r.st      = AOL_ST_WAIT;
                        next_r.target  = raw;
                        next_r.tick    = TICK_RST;
                        next_r.ms_left = wait_ms;
                    end
                end
            end
            AOL_ST_WAIT: begin
                // A glitch shorter than the time is dropped, not stored
                if (raw != r.target) begin
                    next_r.st = AOL_ST_STABLE;
                end else if (r.tick == TICK_LAST) begin
                    next_r.tick = TICK_RST;
                    if (r.ms_left == 16'h0001) begin
                        next_r.state = r.target;
                        next_r.st    = AOL_ST_STABLE;
                    end else begin
                        next_r.ms_left = r.ms_left - 16'h0001;
                    end
                end else begin
                    next_r.tick = r.tick + 18'h00001;
                end
            end
            default: begin
                next_r.st = AOL_ST_STABLE;
            end
        endcase

        // Output mux
        if (LOGIC_MODE) begin
            next_r.out = next_r.state ? OUT_MAX_VALUE : OUT_MIN_VALUE;
        end else begin
            next_r.out = scaled;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r.st       <= AOL_ST_STABLE;
            r.state    <= 1'b0;
            r.target   <= 1'b0;
            r.tick     <= TICK_RST;
            r.ms_left  <= DELAY_RST_MS;
            r.level    <= AOL_LVL_ACTIVE_HIGH;
            r.delay    <= DELAY_RST_MS;
            r.hold     <= HOLD_RST_MS;
            r.rejected <= 1'b0;
            r.out      <= OUT_RST;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ANALOG_OUTPUT_ONE = r.out;
    assign LOGIC_STATE       = r.state;
    assign CHANGE_PENDING    = (r.st == AOL_ST_WAIT);
    assign EFF_ACTIVE_LEVEL  = r.level;
    assign EFF_DELAY_TIME    = r.delay;
    assign EFF_HOLDING_TIME  = r.hold;
    assign LEVEL_REJECTED    = r.rejected;

endmodule : aol_top
`default_nettype wire

// >>> src/aol_pkg.sv
// Constants and types shared by the analog output conditioning block.
// Assumes a single 200 MHz clock and configuration that is already in that domain.
package aol_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W        = 18;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned VAL_W = 16;
    localparam int unsigned PCT_W = 7;
    localparam int unsigned MS_W  = 16;

    // ------------------------------------------------------------
    // Ranges and values after reset
    // ------------------------------------------------------------
    localparam logic [MS_W-1:0]  DELAY_MAX_MS  = 16'hea60;
    localparam logic [MS_W-1:0]  DELAY_RST_MS  = 16'h0000;
    localparam logic [MS_W-1:0]  HOLD_MAX_MS   = 16'h270f;
    localparam logic [MS_W-1:0]  HOLD_RST_MS   = 16'h0000;
    localparam logic [PCT_W-1:0] PCT_FULL      = 7'h64;
    localparam logic [PCT_W-1:0] SCALE_MIN_RST = 7'h00;
    localparam logic [PCT_W-1:0] SCALE_MAX_RST = 7'h64;
    localparam logic [VAL_W-1:0] OUT_RST       = 16'h0000;
    localparam logic [TICK_W-1:0] TICK_RST     = 18'h00000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        AOL_SRC_NONE           = 3'b000,
        AOL_SRC_NO_DRIVE_FAULT = 3'b001,
        AOL_SRC_BRAKE_CONTROL  = 3'b010,
        AOL_SRC_LINE_CONTACTOR = 3'b011,
        AOL_SRC_OTHER          = 3'b100
    } aol_src_e;

    typedef enum logic {
        AOL_LVL_ACTIVE_HIGH = 1'b0,
        AOL_LVL_ACTIVE_LOW  = 1'b1
    } aol_level_e;

    typedef enum logic [1:0] {
        AOL_ST_STABLE = 2'b00,
        AOL_ST_WAIT   = 2'b01
    } aol_state_e;

endpackage : aol_pkg

// >>> src/aol_scale.sv
// Parameter-to-output scaler for the analog mode.
// Assumes inputs synchronous to clk; output lags by two clock edges.
`timescale 1ns/10ps
`default_nettype none
module aol_scale
    import aol_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic signed [VAL_W-1:0]  param,
    input  wire logic signed [VAL_W-1:0]  lim_lo,
    input  wire logic signed [VAL_W-1:0]  lim_hi,
    input  wire logic        [PCT_W-1:0]  scale_min,
    input  wire logic        [PCT_W-1:0]  scale_max,
    input  wire logic        [VAL_W-1:0]  out_min,
    input  wire logic        [VAL_W-1:0]  out_max,
    output logic             [VAL_W-1:0]  out_val
);
    import aol_pkg::*;

    typedef struct packed {
        logic signed [17:0]      eff_lo;
        logic signed [17:0]      eff_hi;
        logic signed [17:0]      p;
        logic        [VAL_W-1:0] omin;
        logic        [VAL_W-1:0] omax;
        logic        [VAL_W-1:0] out;
    } aol_scale_s;

    aol_scale_s s;
    aol_scale_s next_s;

    // ------------------------------------------------------------
    // Limits, then interpolation
    // ------------------------------------------------------------
    always_comb begin
        logic signed [17:0] span;
        logic signed [25:0] ml;
        logic signed [25:0] mh;
        logic signed [25:0] full;
        logic signed [16:0] dout;
        logic signed [18:0] dp;
        logic signed [18:0] den;
        logic signed [35:0] prod;
        logic signed [35:0] q;
        span = 18'sd0;
        ml   = 26'sd0;
        mh   = 26'sd0;
        full = 26'sd0;
        dout = 17'sd0;
        dp   = 19'sd0;
        den  = 19'sd0;
        prod = 36'sd0;
        q    = 36'sd0;
        next_s = s;
        // Span of the parameter is the 100 % reference
        span = 18'(lim_hi) - 18'(lim_lo);
        full = signed'({19'h00000, PCT_FULL});
        ml   = 26'(span) * signed'({19'h00000, scale_min});
        mh   = 26'(span) * signed'({19'h00000, scale_max});
        next_s.eff_lo = 18'(lim_lo) + 18'(ml / full);
        next_s.eff_hi = 18'(lim_lo) + 18'(mh / full);
        next_s.p      = 18'(param);
        next_s.omin   = out_min;
        next_s.omax   = out_max;
        // Signed difference allows min above max, giving a falling slope
        dout = signed'({1'b0, s.omax}) - signed'({1'b0, s.omin});
        dp   = 19'(s.p) - 19'(s.eff_lo);
        den  = 19'(s.eff_hi) - 19'(s.eff_lo);
        prod = 36'(dout) * 36'(dp);
        if (s.p <= s.eff_lo || den <= 19'sd0) begin
            next_s.out = s.omin;
        end else if (s.p >= s.eff_hi) begin
            next_s.out = s.omax;
        end else begin
            q = prod / 36'(den);
            next_s.out = 16'(signed'({1'b0, s.omin}) + 17'(q));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_val = s.out;

endmodule : aol_scale
`default_nettype wire

// >>> tb/aol_props.sv
// Port-level assertions for the analog output conditioning block.
// Assumes one clock domain; bound to every aol_top instance.
`timescale 1ns/10ps
`default_nettype none
module aol_props
#(
    parameter int unsigned TICK_CYCLES = 4
)(
    input wire logic                              CLK,
    input wire logic                              ARST_N,
    input wire logic                              LOGIC_MODE,
    input wire aol_pkg::aol_src_e                 LOGIC_OUTPUT_ASSIGN,
    input wire logic                              ASSIGNED_INFO,
    input wire aol_pkg::aol_level_e               OUTPUT_ACTIVE_LEVEL,
    input wire logic [aol_pkg::MS_W-1:0]          OUTPUT_DELAY_TIME,
    input wire logic [aol_pkg::MS_W-1:0]          OUTPUT_HOLDING_TIME,
    input wire logic [aol_pkg::VAL_W-1:0]         OUT_MIN_VALUE,
    input wire logic [aol_pkg::VAL_W-1:0]         OUT_MAX_VALUE,
    input wire logic signed [aol_pkg::VAL_W-1:0]  PARAM_VALUE,
    input wire logic signed [aol_pkg::VAL_W-1:0]  PARAM_LOWER_LIMIT,
    input wire logic signed [aol_pkg::VAL_W-1:0]  PARAM_UPPER_LIMIT,
    input wire logic [aol_pkg::PCT_W-1:0]         SCALE_MIN_PERCENT,
    input wire logic [aol_pkg::PCT_W-1:0]         SCALE_MAX_PERCENT,
    input wire logic [aol_pkg::VAL_W-1:0]         ANALOG_OUTPUT_ONE,
    input wire logic                              LOGIC_STATE,
    input wire logic                              CHANGE_PENDING,
    input wire aol_pkg::aol_level_e               EFF_ACTIVE_LEVEL,
    input wire logic [aol_pkg::MS_W-1:0]          EFF_DELAY_TIME,
    input wire logic [aol_pkg::MS_W-1:0]          EFF_HOLDING_TIME,
    input wire logic                              LEVEL_REJECTED
);
    import aol_pkg::*;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic [1:0]      up;
    logic            raw, lock_t, lock_l;
    logic [MS_W-1:0] wait_ms;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end
    assign raw = ASSIGNED_INFO ^ (EFF_ACTIVE_LEVEL == AOL_LVL_ACTIVE_LOW);
    assign wait_ms = ASSIGNED_INFO ? EFF_DELAY_TIME : EFF_HOLDING_TIME;
    assign lock_t = LOGIC_OUTPUT_ASSIGN inside {AOL_SRC_NO_DRIVE_FAULT, AOL_SRC_BRAKE_CONTROL};
    assign lock_l = lock_t || LOGIC_OUTPUT_ASSIGN == AOL_SRC_LINE_CONTACTOR;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_times_forced : assert property (lock_t |=> EFF_DELAY_TIME == 16'h0000
        && EFF_HOLDING_TIME == 16'h0000) else $error("Timer not forced to zero");
    a_delay_sat : assert property (!lock_t |=> EFF_DELAY_TIME ==
        (($past(OUTPUT_DELAY_TIME) > DELAY_MAX_MS) ? DELAY_MAX_MS : $past(OUTPUT_DELAY_TIME)))
        else $error("Delay time wrong");
    a_hold_sat : assert property (!lock_t |=> EFF_HOLDING_TIME ==
        (($past(OUTPUT_HOLDING_TIME) > HOLD_MAX_MS) ? HOLD_MAX_MS : $past(OUTPUT_HOLDING_TIME)))
        else $error("Holding time wrong");
    a_level_lock : assert property (lock_l |=> EFF_ACTIVE_LEVEL == AOL_LVL_ACTIVE_HIGH &&
        LEVEL_REJECTED == ($past(OUTPUT_ACTIVE_LEVEL) == AOL_LVL_ACTIVE_LOW))
        else $error("Locked level not held");
    a_level_pass : assert property (!lock_l |=> !LEVEL_REJECTED &&
        EFF_ACTIVE_LEVEL == $past(OUTPUT_ACTIVE_LEVEL)) else $error("Level not taken");
    a_logic_drive : assert property (LOGIC_MODE && $past(LOGIC_MODE) && up == 2'h3 &&
        $stable(OUT_MIN_VALUE) && $stable(OUT_MAX_VALUE) |->
        ANALOG_OUTPUT_ONE == (LOGIC_STATE ? OUT_MAX_VALUE : OUT_MIN_VALUE))
        else $error("Logic level not min or max");
    a_zero_wait : assert property (raw != LOGIC_STATE && wait_ms == 16'h0000 &&
        !CHANGE_PENDING |=> LOGIC_STATE == $past(raw)) else $error("Undelayed change late");
    a_pend_start : assert property (raw != LOGIC_STATE && wait_ms != 16'h0000 &&
        !CHANGE_PENDING |=> CHANGE_PENDING && $stable(LOGIC_STATE))
        else $error("Delayed change not held back");
    a_state_cause : assert property (!$stable(LOGIC_STATE) |-> $past(raw) == LOGIC_STATE)
        else $error("State changed to wrong polarity");
    c_pending : cover property ($rose(CHANGE_PENDING));
    c_reject  : cover property (LEVEL_REJECTED);
    c_low_on  : cover property (EFF_ACTIVE_LEVEL == AOL_LVL_ACTIVE_LOW && $rose(LOGIC_STATE));
endmodule : aol_props
bind aol_top aol_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);
`default_nettype wire

// >>> tb/aol_load.sv
// Equipment wired to the analog output: samples the level each clock.
// Assumes the output level is a register on the same clock.
`timescale 1ns/10ps
`default_nettype none
module aol_load
(
    input  wire logic [aol_pkg::VAL_W-1:0] clk_level,
    input  wire logic                      clk,
    output logic      [aol_pkg::VAL_W-1:0] seen
);
    import aol_pkg::*;
    // Pure listener, no loading effect on the drive
    always_ff @(posedge clk) begin
        seen <= clk_level;
    end
endmodule : aol_load
`default_nettype wire

// >>> tb/tb_aol_top.sv
// Self-checking bench for the analog output conditioning block.
// Assumes aol_props is bound to the design and aol_load watches the output.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_aol_top;
    import aol_pkg::*;
    localparam int TK = 4;
    logic clk, pend, state, rej, arst_n = 1'b0, mode = 1'b1, info = 1'b0;
    aol_src_e asg = AOL_SRC_NONE;
    aol_level_e lvl = AOL_LVL_ACTIVE_HIGH, eff_lvl;
    logic [MS_W-1:0] dly = 16'h0000, hld = 16'h0000, eff_dly, eff_hld;
    logic [VAL_W-1:0] omin = 16'h0100, omax = 16'hf000, aout, seen;
    logic signed [VAL_W-1:0] p = 16'sh0000, lo = -16'sh0064, hi = 16'sh012c;
    logic [PCT_W-1:0] smin = 7'h00, smax = 7'h64;
    logic [15:0] rs = 16'h0022;
    int bad_count = 0, n_tests = 0;
    aol_top #(.TICK_CYCLES(TK)) DUT (.CLK(clk), .ARST_N(arst_n), .LOGIC_MODE(mode),
        .LOGIC_OUTPUT_ASSIGN(asg), .ASSIGNED_INFO(info), .OUTPUT_ACTIVE_LEVEL(lvl),
        .OUTPUT_DELAY_TIME(dly), .OUTPUT_HOLDING_TIME(hld), .OUT_MIN_VALUE(omin),
        .OUT_MAX_VALUE(omax), .PARAM_VALUE(p), .PARAM_LOWER_LIMIT(lo), .PARAM_UPPER_LIMIT(hi),
        .SCALE_MIN_PERCENT(smin), .SCALE_MAX_PERCENT(smax), .ANALOG_OUTPUT_ONE(aout),
        .LOGIC_STATE(state), .CHANGE_PENDING(pend), .EFF_ACTIVE_LEVEL(eff_lvl),
        .EFF_DELAY_TIME(eff_dly), .EFF_HOLDING_TIME(eff_hld), .LEVEL_REJECTED(rej));
    aol_load u_load (.clk_level(aout), .clk(clk), .seen(seen));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [MS_W-1:0] exp_t(input logic [MS_W-1:0] t, mx);
        if (asg inside {AOL_SRC_NO_DRIVE_FAULT, AOL_SRC_BRAKE_CONTROL}) return 16'h0000;
        return (t > mx) ? mx : t;
    endfunction : exp_t
    function automatic logic [VAL_W-1:0] exp_a();
        longint sp, el, eh;
        sp = longint'(hi) - longint'(lo);
        el = longint'(lo) + sp * longint'(smin) / 100;
        eh = longint'(lo) + sp * longint'(smax) / 100;
        if (eh <= el || p <= el) return omin;
        if (p >= eh) return omax;
        return 16'(longint'(omin) + (longint'(omax) - longint'(omin)) * (p - el) / (eh - el));
    endfunction : exp_a
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    // Counts edges until the state reaches the target
    task automatic flip(input logic v, input logic tgt, input int n);
        int k;
        k = 0;
        info = v;
        while (state !== tgt && k < 2000) begin
            @(negedge clk);
            k++;
        end
        `CHK(k, n)
    endtask : flip
    task automatic ana(input logic signed [VAL_W-1:0] pv, input logic [PCT_W-1:0] a, b);
        p = pv;
        smin = a;
        smax = b;
        step(4);
        `CHK(seen, exp_a())
    endtask : ana
    task automatic stop_test();
        $display("Counts: %0d comparisons, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    // ------------------------------------------------------------
    // Clock, watchdog, sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
    initial begin
        step(6);
        arst_n = 1'b1;
        for (int i = 0; i < 10; i++) begin
            rs = lfsr(rs);
            asg = aol_src_e'(i % 5);
            dly = (i < 5) ? 16'hffff : rs;
            hld = (i < 5) ? 16'hffff : ~rs;
            lvl = aol_level_e'((i < 5) ? 1'b1 : rs[3]);
            step(2);
            `CHK(eff_dly, exp_t(dly, DELAY_MAX_MS))
            `CHK(eff_hld, exp_t(hld, HOLD_MAX_MS))
            `CHK(rej, (asg inside {[1:3]}) && lvl == AOL_LVL_ACTIVE_LOW)
            `CHK(eff_lvl, (asg inside {[1:3]}) ? AOL_LVL_ACTIVE_HIGH : lvl)
        end
        $display("Test configuration done");
        arst_n = 1'b0;
        asg = AOL_SRC_NONE;
        lvl = AOL_LVL_ACTIVE_HIGH;
        dly = 16'h0003;
        hld = 16'h0002;
        step(2);
        `CHK(aout, OUT_RST)
        arst_n = 1'b1;
        step(2);
        flip(1'b1, 1'b1, 3 * TK + 1);
        `CHK(aout, omax)
        flip(1'b0, 1'b0, 2 * TK + 1);
        `CHK(aout, omin)
        info = 1'b1;
        step(5);
        info = 1'b0;
        step(2);
        `CHK({pend, state}, 2'b00)
        dly = 16'h0000;
        hld = 16'h0000;
        lvl = AOL_LVL_ACTIVE_LOW;
        step(3);
        `CHK(state, 1'b1)
        flip(1'b1, 1'b0, 1);
        asg = AOL_SRC_BRAKE_CONTROL;
        lvl = AOL_LVL_ACTIVE_HIGH;
        dly = 16'h0005;
        hld = 16'h0005;
        info = 1'b0;
        step(3);
        flip(1'b1, 1'b1, 1);
        flip(1'b0, 1'b0, 1);
        asg = AOL_SRC_LINE_CONTACTOR;
        lvl = AOL_LVL_ACTIVE_LOW;
        dly = 16'h0001;
        step(3);
        flip(1'b1, 1'b1, TK + 1);
        $display("Test logic output done");
        mode = 1'b0;
        info = 1'b0;
        ana(lo, 7'h00, 7'h64);
        ana(hi, 7'h00, 7'h64);
        ana(16'sh0064, 7'h00, 7'h64);
        ana(16'sh0190, 7'h00, 7'h64);
        ana(-16'sh0028, 7'h19, 7'h4b);
        ana(16'sh00dc, 7'h19, 7'h4b);
        ana(16'sh0064, 7'h19, 7'h4b);
        omin = 16'hf000;
        omax = 16'h0100;
        ana(16'sh0032, 7'h00, 7'h64);
        $display("Test analog corners done");
        for (int i = 0; i < 30; i++) begin
            rs = lfsr(rs);
            lo = {4'hf, rs[11:0]};
            omin = rs;
            rs = lfsr(rs);
            hi = {4'h0, rs[11:0]};
            omax = rs;
            rs = lfsr(rs);
            ana($signed(rs) >>> 3, 7'(rs[5:0] % 50), 7'(50 + rs[9:6] * 3));
        end
        $display("Test analog random done");
        stop_test();
    end
endmodule : tb_aol_top
`default_nettype wire
